// ===== pkg/uv_seq_pkg.sv
// constants for the input under-voltage fault and turn-on sequencer
`default_nettype none
package uv_seq_pkg;
   // command codes
   localparam logic [7:0] CMD_UV_LIMIT = 8'h59;
   localparam logic [7:0] CMD_UV_RESP = 8'h5A;
   localparam logic [7:0] CMD_PG_ON = 8'h5E;
   localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
   localparam logic [7:0] CMD_TURN_ON_RISE_TIME = 8'h61;
   localparam logic [7:0] CMD_BRIEF_STATUS = 8'h78;
   // response byte fields
   localparam int RESP_MODE_HI = 7;
   localparam int RESP_MODE_LO = 6;
   localparam int RESP_RETRY_HI = 5;
   localparam int RESP_RETRY_LO = 3;
   localparam int RESP_TIME_HI = 2;
   localparam int RESP_TIME_LO = 0;
   localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   localparam int STATUS_UV_BIT = 3;
   localparam int STATUS_OFF_BIT = 6;
   // reset values
   localparam logic [15:0] UV_LIMIT_RST = 16'h0000;
   localparam logic [7:0] UV_RESP_RST = 8'h80;
   localparam logic [15:0] PG_ON_RST = 16'h0000;
   localparam logic [15:0] TURN_ON_DELAY_TIME_RST = 16'h001E;
   localparam logic [15:0] TURN_ON_RISE_TIME_RST = 16'h000A;
   // timing
   localparam int CLK_HZ = 40000000;
   localparam int RETRY_STEP_MS = 35;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int TURN_ON_DELAY_TIME_MIN_MS = 3;
   localparam int TURN_ON_DELAY_TIME_MAX_MS = 250;
   localparam int TURN_ON_RISE_TIME_MAX_MS = 100;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_DELAY = 3'b001,
      ST_RISE = 3'b011,
      ST_ON = 3'b010,
      ST_FAULT = 3'b110,
      ST_WAIT = 3'b111
   } seq_state_t;
endpackage
`default_nettype wire

// ===== hw/uv_turn_on_sequencer.sv
// input under-voltage fault response and turn-on sequencer
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
`default_nettype none
module uv_turn_on_sequencer
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // management bus command port
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdWrData,
   input wire logic clearFaults,
   output logic [15:0] cmdRdData,
   output logic cmdRdValid,
   output logic cmdUnsupported,
   // measurements and controls
   input wire logic [15:0] inputVoltage,
   input wire logic [15:0] outputVoltage,
   input wire logic outputEnable,
   input wire logic otherFault,
   // regulator controls and indications
   output logic outputOn,
   output logic rampActive,
   output logic [15:0] rampTargetMs,
   output logic alert_line_n,
   output logic output_good_flag,
   output logic [7:0] briefStatus
);
   import uv_seq_pkg::*;

   logic [15:0] uvLimit_q;
   logic [7:0] uvResp_q;
   logic [15:0] pgOn_q;
   logic [15:0] tonDelay_q;
   logic [15:0] tonRise_q;
   logic uvFlag_q;
   logic alert_q;
   seq_state_t state_q;
   logic [15:0] msCnt_q;
   logic [15:0] cycCnt_q;
   logic [2:0] retriesLeft_q;
   logic msTick;
   logic uvNow;

   function automatic logic [15:0] retry_wait_ms(input logic [2:0] t);
      retry_wait_ms = 16'((32'(t) + 32'd1) * RETRY_STEP_MS);
   endfunction

   // ************************************************************
   // registers on the management bus
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         uvLimit_q <= UV_LIMIT_RST;
         uvResp_q <= UV_RESP_RST;
         pgOn_q <= PG_ON_RST;
         tonDelay_q <= TURN_ON_DELAY_TIME_RST;
         tonRise_q <= TURN_ON_RISE_TIME_RST;
      end
      else if (cmdWrite)
      begin
         case (cmdCode)
            CMD_UV_LIMIT: uvLimit_q <= cmdWrData;
            CMD_UV_RESP: uvResp_q <= cmdWrData[7:0];
            CMD_PG_ON: pgOn_q <= cmdWrData;
            CMD_TURN_ON_DELAY_TIME: tonDelay_q <= cmdWrData;
            CMD_TURN_ON_RISE_TIME: tonRise_q <= cmdWrData;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         cmdRdData <= 16'h0000;
         cmdRdValid <= 1'b0;
         cmdUnsupported <= 1'b0;
      end
      else
      begin
         cmdRdValid <= cmdRead;
         cmdUnsupported <= 1'b0;
         if (cmdRead)
         begin
            case (cmdCode)
               CMD_UV_LIMIT: cmdRdData <= uvLimit_q;
               CMD_UV_RESP: cmdRdData <= {8'h00, uvResp_q};
               CMD_PG_ON: cmdRdData <= pgOn_q;
               CMD_TURN_ON_DELAY_TIME: cmdRdData <= tonDelay_q;
               CMD_TURN_ON_RISE_TIME: cmdRdData <= tonRise_q;
               CMD_BRIEF_STATUS: cmdRdData <= {8'h00, briefStatus};
               default:
               begin
                  cmdRdData <= 16'h0000;
                  cmdUnsupported <= 1'b1;
               end
            endcase
         end
         else if (cmdWrite)
         begin
            case (cmdCode)
               CMD_UV_LIMIT, CMD_UV_RESP, CMD_PG_ON, CMD_TURN_ON_DELAY_TIME, CMD_TURN_ON_RISE_TIME: ;
               default: cmdUnsupported <= 1'b1;
            endcase
         end
      end
   end

   // ************************************************************
   // fault detection and status
   // ************************************************************
   // plain unsigned compare; both sides share one scaling
   assign uvNow = inputVoltage < uvLimit_q;

   // set wins over a clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         uvFlag_q <= 1'b0;
         alert_q <= 1'b0;
      end
      else if (uvNow)
      begin
         uvFlag_q <= 1'b1;
         alert_q <= 1'b1;
      end
      else if (clearFaults)
      begin
         uvFlag_q <= 1'b0;
         alert_q <= 1'b0;
      end
   end

   always_comb
   begin
      briefStatus = 8'h00;
      briefStatus[STATUS_UV_BIT] = uvFlag_q;
      briefStatus[STATUS_OFF_BIT] = (state_q == ST_OFF) && !outputEnable;
   end
   assign alert_line_n = !alert_q;

   // ************************************************************
   // millisecond time base
   // ************************************************************
   // free-running, so the first ms of a phase may run short by under 1 ms
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cycCnt_q <= 16'h0000;
      else if (msTick)
         cycCnt_q <= 16'h0000;
      else
         cycCnt_q <= cycCnt_q + 16'h0001;
   end
   assign msTick = cycCnt_q == 16'(CYC_PER_MS - 1);

   // ************************************************************
   // turn-on and retry sequencer
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_q <= ST_OFF;
         msCnt_q <= 16'h0000;
         retriesLeft_q <= 3'h0;
      end
      else if (!outputEnable || otherFault)
      begin
         // disable or another fault ends any retrying
         state_q <= ST_OFF;
         msCnt_q <= 16'h0000;
      end
      else
      begin
         case (state_q)
            ST_OFF:
            begin
               // turn-on delay is used as written, with no clamp to the 3 to 250 ms range
               if (!uvNow)
               begin
                  state_q <= ST_DELAY;
                  msCnt_q <= 16'h0000;
                  retriesLeft_q <= uvResp_q[RESP_RETRY_HI:RESP_RETRY_LO];
               end
            end
            ST_DELAY, ST_RISE, ST_ON:
            begin
               if (uvNow && uvResp_q[RESP_MODE_HI:RESP_MODE_LO] == MODE_DISABLE_RETRY)
               begin
                  state_q <= ST_FAULT;
                  msCnt_q <= 16'h0000;
               end
               else if (state_q == ST_DELAY && msCnt_q >= tonDelay_q)
               begin
                  state_q <= ST_RISE;
                  msCnt_q <= 16'h0000;
               end
               else if (state_q == ST_RISE && msCnt_q >= tonRise_q)
               begin
                  state_q <= ST_ON;
               end
               else if (msTick && state_q != ST_ON)
                  msCnt_q <= msCnt_q + 16'h0001;
            end
            ST_FAULT:
            begin
               // zero count holds off until the fault flag clears; a spent count holds off until enable cycles
               if (uvResp_q[RESP_RETRY_HI:RESP_RETRY_LO] == RETRY_NONE)
               begin
                  if (!uvFlag_q)
                     state_q <= ST_OFF;
               end
               // endless retry follows the live field, even if the count was loaded under another setting
               else if (retriesLeft_q != 3'h0 || uvResp_q[RESP_RETRY_HI:RESP_RETRY_LO] == RETRY_FOREVER)
               begin
                  state_q <= ST_WAIT;
                  msCnt_q <= 16'h0000;
               end
            end
            ST_WAIT:
            begin
               if (msCnt_q >= retry_wait_ms(uvResp_q[RESP_TIME_HI:RESP_TIME_LO]))
               begin
                  if (uvResp_q[RESP_RETRY_HI:RESP_RETRY_LO] != RETRY_FOREVER)
                     retriesLeft_q <= retriesLeft_q - 3'h1;
                  if (!uvNow)
                  begin
                     state_q <= ST_DELAY;
                     msCnt_q <= 16'h0000;
                  end
                  else
                     state_q <= ST_FAULT;
               end
               else if (msTick)
                  msCnt_q <= msCnt_q + 16'h0001;
            end
            default: state_q <= ST_OFF;
         endcase
      end
   end

   // ************************************************************
   // outputs to the power stage
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         outputOn <= 1'b0;
         rampActive <= 1'b0;
         rampTargetMs <= 16'h0000;
         output_good_flag <= 1'b0;
      end
      else
      begin
         outputOn <= state_q == ST_RISE || state_q == ST_ON;
         rampActive <= state_q == ST_RISE;
         rampTargetMs <= tonRise_q;
         output_good_flag <= (state_q == ST_RISE || state_q == ST_ON) && outputVoltage >= pgOn_q;
      end
   end
endmodule
`default_nettype wire

// ===== verif/uv_seq_properties.sv
// port checker for the under-voltage sequencer
`timescale 1ns/1ps
`default_nettype none
module uv_seq_properties
(
   // inputs of the block
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdWrData,
   input wire logic [15:0] inputVoltage,
   input wire logic [15:0] outputVoltage,
   input wire logic outputEnable,
   // outputs of the block
   input wire logic cmdRdValid,
   input wire logic cmdUnsupported,
   input wire logic outputOn,
   input wire logic alert_line_n,
   input wire logic output_good_flag,
   input wire logic [7:0] briefStatus
);
   import uv_seq_pkg::*;
   // ****
   // shadow settings, seen only through bus writes
   // ****
   logic [15:0] lim_q;
   logic [15:0] pg_q;
   logic [7:0] resp_q;
   logic known;
   logic mode10;
   assign known = (cmdCode inside {CMD_UV_LIMIT, CMD_UV_RESP, CMD_PG_ON, CMD_TURN_ON_DELAY_TIME, CMD_TURN_ON_RISE_TIME})
      || (cmdCode == CMD_BRIEF_STATUS && !cmdWrite);
   assign mode10 = resp_q[RESP_MODE_HI:RESP_MODE_LO] == MODE_DISABLE_RETRY;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         lim_q <= UV_LIMIT_RST;
         pg_q <= PG_ON_RST;
         resp_q <= UV_RESP_RST;
      end
      else if (cmdWrite && cmdCode == CMD_UV_LIMIT)
         lim_q <= cmdWrData;
      else if (cmdWrite && cmdCode == CMD_PG_ON)
         pg_q <= cmdWrData;
      else if (cmdWrite && cmdCode == CMD_UV_RESP)
         resp_q <= cmdWrData[7:0];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_bad_access;
      (cmdRead || cmdWrite) && !known;
   endsequence
   a_read_answer: assert property (cmdRead |=> cmdRdValid)
      else $error("read not answered");
   a_bad_code: assert property (s_bad_access |=> cmdUnsupported)
      else $error("unknown code accepted");
   a_uv_alert: assert property (inputVoltage < lim_q |-> ##[1:2] !alert_line_n)
      else $error("no alert on low input");
   a_status_alert: assert property (briefStatus[STATUS_UV_BIT] == !alert_line_n)
      else $error("status bit and alert differ");
   a_uv_off: assert property (mode10 && outputOn && inputVoltage < lim_q |-> ##[1:3] !outputOn)
      else $error("output not shut down");
   a_no_retry: assert property (mode10 && resp_q[5:3] == RETRY_NONE && !alert_line_n && !outputOn |=> !outputOn)
      else $error("restart without clear");
   a_pg_low: assert property ((outputVoltage < pg_q) [*2] |-> !output_good_flag)
      else $error("power good below threshold");
   a_turn_on: assert property ($rose(outputOn) |-> $past(outputEnable))
      else $error("output on without enable");
endmodule
bind uv_turn_on_sequencer uv_seq_properties u_props (.*);
`default_nettype wire

// ===== verif/host_model.sv
// host controller model for the command port
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   // clock
   input wire logic sys_clk,
   // command port
   output logic cmdWrite,
   output logic cmdRead,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdWrData,
   input wire logic [15:0] cmdRdData,
   input wire logic cmdUnsupported
);
   initial
   begin
      cmdWrite = 1'b0;
      cmdRead = 1'b0;
      cmdCode = 8'h00;
      cmdWrData = 16'h0000;
   end
   // byte settings travel in the low byte of a whole word
   task automatic wr(input logic [7:0] code, input logic [15:0] data, output logic unsup);
      @(posedge sys_clk);
      #1;
      cmdCode = code;
      cmdWrData = data;
      cmdWrite = 1'b1;
      @(posedge sys_clk);
      #1;
      cmdWrite = 1'b0;
      cmdWrData = ~data;
      unsup = cmdUnsupported;
   endtask
   task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic unsup);
      @(posedge sys_clk);
      #1;
      cmdCode = code;
      cmdRead = 1'b1;
      @(posedge sys_clk);
      #1;
      cmdRead = 1'b0;
      data = cmdRdData;
      unsup = cmdUnsupported;
   endtask
endmodule
`default_nettype wire

// ===== verif/tb_uv_turn_on_sequencer.sv
// testbench for the under-voltage sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_uv_turn_on_sequencer;
   import uv_seq_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clearFaults = 1'b0;
   logic outputEnable = 1'b0;
   logic otherFault = 1'b0;
   logic [15:0] inputVoltage = 16'h0300;
   logic [15:0] outputVoltage = 16'h0000;
   logic cmdWrite, cmdRead, cmdRdValid, cmdUnsupported, outputOn, rampActive, alert_line_n, output_good_flag;
   logic [7:0] cmdCode, briefStatus;
   logic [15:0] cmdWrData, cmdRdData, rampTargetMs, rdv;
   logic unsup;
   int fail_count = 0;
   int comparisons = 0;
   logic [7:0] codes [5] = '{CMD_UV_LIMIT, CMD_UV_RESP, CMD_PG_ON, CMD_TURN_ON_DELAY_TIME, CMD_TURN_ON_RISE_TIME};
   logic [15:0] rstv [5] = '{UV_LIMIT_RST, {8'h00, UV_RESP_RST}, PG_ON_RST, TURN_ON_DELAY_TIME_RST, TURN_ON_RISE_TIME_RST};
   logic [15:0] pat [5] = '{16'h0123, 16'h0034, 16'h1233, 16'h2343, 16'h3453};
   // zero turn-on delay is safe here: enable comes from the pin, never from input power alone
   logic [15:0] cfg [5] = '{16'h0200, 16'h0080, 16'h0100, 16'h0000, 16'h0000};
   always #12.5 sys_clk = ~sys_clk;
   uv_turn_on_sequencer i_uv_turn_on_sequencer (.*);
   host_model host (.*);
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic clear_flag;
      clearFaults = 1'b1;
      step(1);
      clearFaults = 1'b0;
      step(8);
   endtask
   task automatic finish_test;
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // a hang costs a mismatch
   initial
   begin
      #125000;
      fail_count++;
      finish_test();
   end
   initial
   begin
      step(10);
      rst = 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         host.rd(codes[i], rdv, unsup);
         chk("reset value", rstv[i], rdv);
         host.wr(codes[i], pat[i], unsup);
         host.rd(codes[i], rdv, unsup);
         chk("read back", pat[i], rdv);
      end
      host.rd(8'h33, rdv, unsup);
      chk("unknown read", 16'h0001, 16'(unsup));
      host.wr(CMD_BRIEF_STATUS, 16'h0000, unsup);
      chk("status write", 16'h0001, 16'(unsup));
      for (int i = 0; i < 5; i++)
         host.wr(codes[i], cfg[i], unsup);
      outputEnable = 1'b1;
      step(3);
      chk("ramp active", 16'h0001, 16'(rampActive));
      step(3);
      chk("turn on", 16'h0001, 16'(outputOn));
      chk("rise time", 16'h0000, rampTargetMs);
      chk("ramp done", 16'h0000, 16'(rampActive));
      outputVoltage = 16'h00FF;
      step(2);
      chk("power good low", 16'h0000, 16'(output_good_flag));
      outputVoltage = 16'h0100;
      step(2);
      chk("power good", 16'h0001, 16'(output_good_flag));
      inputVoltage = 16'h01FF;
      step(4);
      chk("alert", 16'h0000, 16'(alert_line_n));
      chk("status", 16'h0008, 16'(briefStatus));
      chk("shutdown", 16'h0000, 16'(outputOn));
      inputVoltage = 16'h0300;
      step(100);
      chk("stays off", 16'h0000, 16'(outputOn));
      clear_flag();
      chk("restart", 16'h0001, 16'(outputOn));
      chk("alert cleared", 16'h0001, 16'(alert_line_n));
      host.wr(CMD_UV_RESP, 16'h0000, unsup);
      inputVoltage = 16'h01FF;
      step(4);
      chk("alert other mode", 16'h0000, 16'(alert_line_n));
      chk("no shutdown", 16'h0001, 16'(outputOn));
      inputVoltage = 16'h0300;
      clear_flag();
      host.wr(CMD_UV_RESP, 16'h00B9, unsup);
      inputVoltage = 16'h01FF;
      step(4);
      chk("retry shutdown", 16'h0000, 16'(outputOn));
      inputVoltage = 16'h0300;
      step(2000);
      chk("retry wait", 16'h0000, 16'(outputOn));
      otherFault = 1'b1;
      step(2);
      otherFault = 1'b0;
      step(6);
      chk("restart after other fault", 16'h0001, 16'(outputOn));
      outputEnable = 1'b0;
      step(2);
      chk("disabled", 16'h0000, 16'(outputOn));
      chk("off status", 16'h0048, 16'(briefStatus));
      finish_test();
   end
endmodule
`default_nettype wire
